// ### isa_bridge_misc_config.sv
// APB register bank: ISA wait select, IDE enable, strobe pin, scratch,
// RTC index mirror, standby wake masks and an event interrupt.
// Assumes IRQ, NMI and strap pins are asynchronous; port 70h strobe is
// on core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module isa_bridge_misc_config
  import isa_misc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rtc_index_wr_in,
  input wire logic [7:0] rtc_index_data_in,
  input wire logic ide_enable_strap_in,
  input wire logic [15:1] irq_in,
  input wire logic nmi_in,
  output logic isa16_one_wait_out,
  output logic ide_enable_out,
  output logic prog_pulse_out,
  output logic sys_wake_out,
  output logic mon_wake_out,
  output logic irq_out
);
  logic [7:0] cfg80_r;
  logic [7:0] cfg81_r;
  logic [7:0] scratch_r;
  logic [7:0] mirror_r;
  wake_mask_t sys_mask_r;
  wake_mask_t mon_mask_r;
  logic [STAT_WIDTH-1:0] stat_r;
  logic [STAT_WIDTH-1:0] en_r;
  logic strap_r;
  logic [1:0] strap_age_r;
  logic [16:0] pin_level;
  logic [16:0] pin_rise;
  logic [15:0] line_event;
  logic [3:0] base;
  logic hit;
  logic [7:0] idx;
  logic wr_go;
  logic rd_go;
  logic [7:0] rd_val;
  logic sys_wake_nxt;
  logic mon_wake_nxt;
  logic prog_nxt;
  logic [STAT_WIDTH-1:0] events;

  sync_rise #(.WIDTH(17)) u_pins (
    .clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({ide_enable_strap_in, irq_in, nmi_in}),
    .level_out(pin_level),
    .rise_out(pin_rise)
  );

  // Register window follows the relocation bit
  assign base = cfg80_r[CFG80_RELOC_BIT] ? BASE_MOVED : BASE_HOME; // RULE11
  assign hit = (paddr_in[11:10] == 2'b00) && (paddr_in[9:6] == base);
  assign idx = {4'h8, paddr_in[5:2]};
  // Access phase lasts two cycles: pready raised on the second
  assign rd_go = psel_in && penable_in && !pready_out && !pwrite_in;
  assign wr_go = psel_in && penable_in && pready_out && pwrite_in && hit;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !hit;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      IDX_CFG80: rd_val = cfg80_r;
      IDX_CFG81: rd_val = cfg81_r;
      IDX_SCRATCH: rd_val = scratch_r; // RULE5
      IDX_RTC_MIRROR: rd_val = mirror_r; // RULE6
      IDX_SYS_LO: rd_val = {sys_mask_r.irq[7:1], sys_mask_r.nmi};
      IDX_SYS_HI: rd_val = sys_mask_r.irq[15:8];
      IDX_MON_LO: rd_val = {mon_mask_r.irq[7:1], mon_mask_r.nmi};
      IDX_MON_HI: rd_val = mon_mask_r.irq[15:8];
      IDX_IRQ_STAT: rd_val = {5'h00, stat_r};
      IDX_IRQ_EN: rd_val = {5'h00, en_r};
      default: rd_val = 8'h00; // RULE12
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_go) begin
      prdata_out <= hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // Configuration bits; reserved positions stay zero
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg80_r <= CFG80_RESET;
      cfg81_r <= CFG81_RESET;
    end else if (wr_go && idx == IDX_CFG80) begin
      cfg80_r <= pwdata_in[7:0] & CFG80_MASK; // RULE12
    end else if (wr_go && idx == IDX_CFG81) begin
      cfg81_r <= pwdata_in[7:0] & CFG81_MASK; // RULE12
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scratch_r <= SCRATCH_RESET;
    end else if (wr_go && idx == IDX_SCRATCH) begin
      scratch_r <= pwdata_in[7:0]; // RULE5
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mirror_r <= MIRROR_RESET;
    end else if (rtc_index_wr_in) begin
      mirror_r <= rtc_index_data_in; // RULE6
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sys_mask_r <= MASK_RESET;
      mon_mask_r <= MASK_RESET;
    end else if (wr_go) begin
      if (idx == IDX_SYS_LO) begin
        {sys_mask_r.irq[7:1], sys_mask_r.nmi} <= pwdata_in[7:0]; // RULE7
      end
      if (idx == IDX_SYS_HI) begin
        sys_mask_r.irq[15:8] <= pwdata_in[7:0]; // RULE7
      end
      if (idx == IDX_MON_LO) begin
        {mon_mask_r.irq[7:1], mon_mask_r.nmi} <= pwdata_in[7:0]; // RULE9
      end
      if (idx == IDX_MON_HI) begin
        mon_mask_r.irq[15:8] <= pwdata_in[7:0]; // RULE9
      end
    end
  end

  // Strap taken once the synchroniser holds a real pin sample
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_r <= 1'b0;
      strap_age_r <= 2'h0;
    end else if (strap_age_r <= STRAP_SETTLE) begin
      strap_age_r <= strap_age_r + 2'h1;
      if (strap_age_r == STRAP_SETTLE) begin
        strap_r <= pin_level[16]; // RULE3
      end
    end
  end

  assign line_event = pin_rise[15:0];
  assign sys_wake_nxt = |(line_event & ~sys_mask_r); // RULE7 RULE8
  assign mon_wake_nxt = |(line_event & ~mon_mask_r); // RULE9 RULE10
  assign prog_nxt = wr_go && idx == IDX_STROBE
    && cfg80_r[CFG80_PROG_EN_BIT]; // RULE4

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      isa16_one_wait_out <= 1'b1;
      ide_enable_out <= 1'b0;
      prog_pulse_out <= 1'b0;
      sys_wake_out <= 1'b0;
      mon_wake_out <= 1'b0;
    end else begin
      isa16_one_wait_out <= !cfg81_r[CFG81_WAIT_BIT]; // RULE1
      ide_enable_out <= strap_r && !cfg81_r[CFG81_IDE_DIS_BIT]; // RULE2 RULE3
      prog_pulse_out <= prog_nxt; // RULE4
      sys_wake_out <= sys_wake_nxt; // RULE7 RULE8
      mon_wake_out <= mon_wake_nxt; // RULE9 RULE10
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign events = {prog_nxt, mon_wake_nxt, sys_wake_nxt};

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stat_r <= '0;
    end else if (wr_go && idx == IDX_IRQ_CLR) begin
      stat_r <= (stat_r & ~pwdata_in[STAT_WIDTH-1:0]) | events;
    end else begin
      stat_r <= stat_r | events;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_r <= '0;
    end else if (wr_go && idx == IDX_IRQ_EN) begin
      en_r <= pwdata_in[STAT_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((stat_r | events) & en_r);
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_wait_select: assert property ( // RULE1
    wr_go && idx == IDX_CFG81 |=> ##1
      isa16_one_wait_out == !$past(pwdata_in[CFG81_WAIT_BIT], 2))
    else $error("wait state select not applied");

  chk_ide_enable_ctl: assert property ( // RULE2
    wr_go && idx == IDX_CFG81 && strap_r |=> ##1
      ide_enable_out == !$past(pwdata_in[CFG81_IDE_DIS_BIT], 2))
    else $error("ide enable does not follow control bit");

  chk_ide_strap_gate: assert property ( // RULE3
    ide_enable_out |-> strap_r)
    else $error("ide enabled with strap low");

  chk_strobe_pulse: assert property ( // RULE4
    prog_nxt |=> prog_pulse_out ##1 !prog_pulse_out)
    else $error("strobe pulse not exactly one cycle");

  chk_strobe_gate: assert property ( // RULE4
    prog_pulse_out |-> $past(cfg80_r[CFG80_PROG_EN_BIT])
      && $past(wr_go) && $past(idx) == IDX_STROBE)
    else $error("strobe pulse without enabled strobe write");

  chk_scratch_keep: assert property ( // RULE5
    wr_go && idx == IDX_SCRATCH |=> scratch_r == $past(pwdata_in[7:0]))
    else $error("scratch value lost");

  chk_rtc_mirror: assert property ( // RULE6
    rtc_index_wr_in |=> mirror_r == $past(rtc_index_data_in))
    else $error("rtc index mirror stale");

  chk_sys_wake: assert property ( // RULE7
    |(line_event & ~sys_mask_r) |=> sys_wake_out)
    else $error("unmasked line did not wake system standby");

  chk_sys_nmi_wake: assert property ( // RULE8
    line_event[0] && !sys_mask_r.nmi |=> sys_wake_out)
    else $error("nmi did not wake system standby");

  chk_mon_wake: assert property ( // RULE9
    mon_wake_out |-> $past(|(line_event & ~mon_mask_r)))
    else $error("monitor wake without unmasked event");

  chk_mon_nmi_wake: assert property ( // RULE10
    line_event[0] && !mon_mask_r.nmi |=> mon_wake_out)
    else $error("nmi did not wake monitor standby");

  chk_reloc_base: assert property ( // RULE11
    wr_go && idx == IDX_CFG80 && pwdata_in[CFG80_RELOC_BIT]
      |=> base == BASE_MOVED)
    else $error("register window not relocated");

  chk_rsvd_zero: assert property ( // RULE12
    rd_go && hit && idx == IDX_RSVD82 |=> prdata_out == 32'h0000_0000)
    else $error("reserved register not zero");

  cov_strobe: cover property (prog_pulse_out);
  cov_sys_wake: cover property (sys_wake_out);
  cov_mon_wake: cover property (mon_wake_out);
  cov_relocated: cover property (cfg80_r[CFG80_RELOC_BIT] && wr_go);
endmodule : isa_bridge_misc_config
`default_nettype wire

// ### isa_bridge_misc_config_tb.sv
// Self-checking bench for the ISA bridge miscellaneous configuration bank.
// Assumes the bank answers every APB access with pready; no other model.
`timescale 1ns/1ps
`default_nettype none
module isa_bridge_misc_config_tb;
  import isa_misc_pkg::*;
  logic core_clk_in;
  logic reset_n_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, rtc_wr = 0, strap = 1, nmi = 0;
  logic [7:0] rtc_d = 0;
  logic [15:1] irq = 0;
  logic one_wait, ide_en, prog, sys_w, mon_w, irq_o;
  logic [3:0] base = BASE_HOME;
  logic [15:0] m;
  logic [32:0] rd_q[$];
  logic [2:0] ev_q[$];
  int bad_count = 0, total_checks = 0, k;

  isa_bridge_misc_config i_dut (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .rtc_index_wr_in(rtc_wr), .rtc_index_data_in(rtc_d),
    .ide_enable_strap_in(strap), .irq_in(irq), .nmi_in(nmi),
    .isa16_one_wait_out(one_wait), .ide_enable_out(ide_en),
    .prog_pulse_out(prog), .sys_wake_out(sys_w), .mon_wake_out(mon_w),
    .irq_out(irq_o));

  initial begin
    core_clk_in = 0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  task chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task idle(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : idle

  // Setup, access until pready, release, then one idle edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1);
    chk(n, 2);
    psel <= 0;
    penable <= 0;
    @(posedge core_clk_in);
  endtask : apb

  task wr(input logic [7:0] i, input logic [31:0] d);
    apb(1, {2'b00, base, i[3:0], 2'b00}, d);
  endtask : wr

  task rda(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(0, a, 0);
  endtask : rda

  task rd(input logic [7:0] i, input logic [32:0] e);
    rda({2'b00, base, i[3:0], 2'b00}, e);
  endtask : rd

  // Results are matched against the oldest note of each kind
  always @(posedge core_clk_in) begin
    if (reset_n_in && psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata},
        rd_q.size() ? rd_q.pop_front() : 33'h1_ffff_ffff);
    if (reset_n_in && {mon_w, sys_w, prog} !== 3'b000)
      chk({mon_w, sys_w, prog}, ev_q.size() ? ev_q.pop_front() : 3'b000);
  end

  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    r = $urandom(32'hb216);
    idle(10);
    reset_n_in <= 1;
    idle(6);
    chk(one_wait, 1);
    chk(ide_en, 1);
    for (k = 7; k <= 10; k++) rd(8'h80 + k[7:0], 33'hff);
    wr(IDX_CFG81, 32'hffffffff);
    idle(3);
    chk(one_wait, 0);
    chk(ide_en, 0);
    rd(IDX_CFG81, 33'h06);
    wr(IDX_CFG81, 0);
    idle(3);
    chk(one_wait, 1);
    chk(ide_en, 1);
    wr(IDX_STROBE, $urandom);
    wr(IDX_CFG80, 32'h10);
    rd(IDX_CFG80, 33'h10);
    ev_q.push_back(3'b001);
    wr(IDX_STROBE, $urandom);
    ev_q.push_back(3'b001);
    ev_q.push_back(3'b001);
    wr(IDX_STROBE, 0);
    wr(IDX_STROBE, $urandom);
    rd(IDX_STROBE, 0);
    wr(IDX_RSVD82, 32'hff);
    rd(IDX_RSVD82, 0);
    rd(IDX_IRQ_STAT, 33'h04);
    chk(irq_o, 0);
    wr(IDX_IRQ_EN, 32'h04);
    idle(2);
    chk(irq_o, 1);
    wr(IDX_IRQ_CLR, 32'h04);
    idle(2);
    chk(irq_o, 0);
    rd(IDX_IRQ_STAT, 0);
    repeat (4) begin
      r = $urandom;
      wr(IDX_SCRATCH, r);
      rd(IDX_SCRATCH, {25'h0, r[7:0]});
    end
    r = $urandom;
    rtc_d <= r[7:0];
    rtc_wr <= 1;
    @(posedge core_clk_in);
    rtc_wr <= 0;
    @(posedge core_clk_in);
    rd(IDX_RTC_MIRROR, {25'h0, r[7:0]});
    // One line unmasked at a time; monitor mask opened on odd lines
    for (k = 0; k < 17; k++) begin
      m = 16'hffff;
      if (k < 16) m[k] = 1'b0;
      wr(IDX_SYS_LO, m[7:0]);
      wr(IDX_SYS_HI, m[15:8]);
      wr(IDX_MON_LO, k[0] ? m[7:0] : 8'hff);
      wr(IDX_MON_HI, k[0] ? m[15:8] : 8'hff);
      if (k < 16) ev_q.push_back({k[0], 2'b10});
      {irq, nmi} <= (k < 16) ? ~m : 16'hffff;
      idle(10);
      {irq, nmi} <= 0;
      idle(6);
    end
    wr(IDX_CFG80, 32'h12);
    base = BASE_MOVED;
    wr(IDX_SCRATCH, 32'h5a);
    rd(IDX_SCRATCH, 33'h5a);
    rda({2'b00, IDX_SCRATCH, 2'b00}, 33'h100000000);
    wr(IDX_CFG80, 0);
    base = BASE_HOME;
    rd(IDX_SCRATCH, 33'h5a);
    rda(12'h240, 33'h100000000);
    strap <= 0;
    reset_n_in <= 0;
    idle(10);
    reset_n_in <= 1;
    idle(6);
    chk(one_wait, 1);
    wr(IDX_CFG81, 0);
    idle(3);
    chk(ide_en, 0);
    idle(4);
    chk({1'b0, 32'(rd_q.size() + ev_q.size())}, 0);
    tally_and_finish();
  end
endmodule : isa_bridge_misc_config_tb
`default_nettype wire

// ### isa_misc_pkg.sv
// Constants and types of the ISA bridge miscellaneous configuration block.
// Assumes an APB master on the bridge clock; byte address = 4 * index.
// Function
// RULE1 - Wait-select bit 0 gives one 16-bit ISA wait state, 1 gives none.
// RULE2 - IDE control bit 0 enables integrated IDE, 1 disables it.
// RULE3 - IDE control bit honoured only when strap, sampled at reset, is high.
// RULE4 - Any strobe register write pulses output once while bit 4 of 80h set.
// RULE5 - Scratch register keeps and returns the written value, nothing else.
// RULE6 - Mirror register returns last value written to RTC index port 70h.
// RULE7 - System-standby mask per IRQ1-15; unmasked line event exits standby.
// RULE8 - System-standby NMI mask; unmasked NMI event exits system standby.
// RULE9 - Monitor-standby mask per IRQ1-15; unmasked event exits monitor standby.
// RULE10 - Monitor-standby NMI mask; unmasked NMI event exits monitor standby.
// RULE11 - Registers at index 80h-8Fh; move to 70h-7Fh when 80h bit 1 set.
// RULE12 - Reserved bits read zero and ignore writes.
package isa_misc_pkg;
  localparam logic [3:0] BASE_HOME = 4'h8;
  localparam logic [3:0] BASE_MOVED = 4'h7;
  localparam logic [7:0] IDX_CFG80 = 8'h80;
  localparam logic [7:0] IDX_CFG81 = 8'h81;
  localparam logic [7:0] IDX_RSVD82 = 8'h82;
  localparam logic [7:0] IDX_STROBE = 8'h83;
  localparam logic [7:0] IDX_SCRATCH = 8'h85;
  localparam logic [7:0] IDX_RTC_MIRROR = 8'h86;
  localparam logic [7:0] IDX_SYS_LO = 8'h87;
  localparam logic [7:0] IDX_SYS_HI = 8'h88;
  localparam logic [7:0] IDX_MON_LO = 8'h89;
  localparam logic [7:0] IDX_MON_HI = 8'h8a;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h8c;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h8d;
  localparam logic [7:0] IDX_IRQ_EN = 8'h8e;
  localparam int CFG80_RELOC_BIT = 1;
  localparam int CFG80_PROG_EN_BIT = 4;
  localparam int CFG81_IDE_DIS_BIT = 1;
  localparam int CFG81_WAIT_BIT = 2;
  localparam logic [7:0] CFG80_MASK = 8'h12;
  localparam logic [7:0] CFG81_MASK = 8'h06;
  localparam logic [7:0] CFG80_RESET = 8'h00;
  localparam logic [7:0] CFG81_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] MIRROR_RESET = 8'h00;
  localparam logic [15:0] MASK_RESET = 16'hffff;
  // Edges after reset release before the synchronised strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int STAT_SYS_WAKE = 0;
  localparam int STAT_MON_WAKE = 1;
  localparam int STAT_PROG_PULSE = 2;
  localparam int STAT_WIDTH = 3;
  // Bit 0 is NMI, bits 15:1 are IRQ15..IRQ1; a set bit blocks wake-up
  typedef struct packed {
    logic [15:1] irq;
    logic nmi;
  } wake_mask_t;
endpackage : isa_misc_pkg

// ### sync_rise.sv
// Two-flop synchroniser with rising-edge detect, one per input bit.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module sync_rise #(
  parameter int WIDTH = 17
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  if (WIDTH < 1) begin : g_width_check
    $error("sync_rise needs a WIDTH of at least 1");
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
endmodule : sync_rise
`default_nettype wire
